/* File: design/bus_master_regs.vh */
// Constants for the bus master controller that drives the memory slave
`ifndef BUS_MASTER_REGS_VH
`define BUS_MASTER_REGS_VH
`define CLK_PERIOD_NS 100
`define HALT_MIN_US 25
`define HALT_CYCLES ((`HALT_MIN_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REFRESH_PERIOD_US 1600
`define REFRESH_CYCLES ((`REFRESH_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define REFRESH_ROWS 128
`define REPLY_TIMEOUT 16'h0040
`define ADDR_W 22
`define DATA_W 16
`endif

/* File: design/cycle_timer.v */
// Down counter that flags expiry after a loaded number of cycles
`default_nettype none
module cycle_timer #(
	parameter W = 16
) (
	// Clock and control
	input wire clk_in,
	input wire sys_rst_in,
	input wire ce_in,
	input wire load_in,
	input wire [W-1:0] count_in,
	// Status
	output reg done_out
);
	reg [W-1:0] cnt_q;
	// Reloads on request, otherwise counts down to zero and holds
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			cnt_q <= {W{1'b0}};
			done_out <= 1'b0;
		end else if (ce_in) begin
			if (load_in) begin
				cnt_q <= count_in;
				done_out <= 1'b0;
			end else if (cnt_q != {W{1'b0}}) begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				done_out <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
			end
		end
	end
endmodule // cycle_timer
`default_nettype wire

/* File: design/bus_master_ctrl.v */
// Bus master controller: cycles, DMA arbitration, halt, refresh, interrupts
`include "bus_master_regs.vh"
`default_nettype none
module bus_master_ctrl #(
	parameter ADDR_W = `ADDR_W,
	parameter DATA_W = `DATA_W,
	parameter HALT_CYCLES = `HALT_CYCLES,
	parameter REFRESH_CYCLES = `REFRESH_CYCLES,
	parameter REFRESH_ROWS = `REFRESH_ROWS
) (
	// Clock, reset, enable
	input wire clk_in,
	input wire sys_rst_in,
	input wire ce_in,
	// User request port
	input wire req_valid_in,
	input wire req_write_in,
	input wire [ADDR_W-1:0] req_addr_in,
	input wire [DATA_W-1:0] req_wdata_in,
	output reg req_ready_out,
	output reg rsp_valid_out,
	output reg [DATA_W-1:0] rsp_rdata_out,
	output reg rsp_err_out,
	output reg rsp_timeout_out,
	// Status to user
	output reg halted_out,
	output reg irq5_out,
	output reg irq6_out,
	output reg dma_owner_out,
	// Bus strobes (active low lines, asserted = 1 here)
	output reg sync_strobe_out,
	output reg read_strobe_out,
	output reg write_strobe_out,
	output reg refresh_strobe_out,
	input wire reply_strobe_in,
	// Multiplexed address/data lines
	output reg [DATA_W-1:0] dal_out,
	output reg dal_oe_out,
	input wire [DATA_W-1:0] dal_in,
	output reg ext_addr_bit_a_out,
	output reg ext_addr_bit_a_oe_out,
	input wire ext_addr_bit_a_in,
	output reg ext_addr_bit_b_out,
	output reg ext_addr_bit_b_oe_out,
	// Arbitration and system lines
	input wire dma_request_line_in,
	output reg dma_grant_out,
	input wire select_acknowledge_in,
	input wire halt_request_in,
	input wire irq_level_five_n_in,
	input wire irq_level_six_n_in
);
	localparam S_IDLE = 3'd0;
	localparam S_ADDR = 3'd1;
	localparam S_DATA = 3'd2;
	localparam S_TERM = 3'd3;
	localparam S_GRANT = 3'd4;
	localparam S_DMA = 3'd5;

	reg [2:0] state_q;
	reg write_q;
	reg refresh_cycle_q;
	reg [DATA_W-1:0] wdata_q;
	reg [15:0] halt_cnt_q;
	reg [15:0] ref_cnt_q;
	reg [7:0] row_q;
	reg ref_due_q;
	wire tmo_done;
	wire tmo_load;

	// Bus is quiet when neither sync nor reply are asserted
	function quiet;
		input s;
		input r;
		quiet = ~s & ~r;
	endfunction

	// Reply timer restarts whenever a cycle is not waiting for reply
	assign tmo_load = (state_q != S_DATA);
	cycle_timer #(.W(16)) reply_timer (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.load_in(tmo_load),
		.count_in(`REPLY_TIMEOUT),
		.done_out(tmo_done)
	);

	// Halt must be held continuously for the minimum time
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			halt_cnt_q <= 16'h0000;
			halted_out <= 1'b0;
		end else if (ce_in) begin
			if (!halt_request_in) begin
				halt_cnt_q <= 16'h0000;
				halted_out <= 1'b0;
			end else if (halt_cnt_q >= HALT_CYCLES[15:0] - 16'h0001) begin
				halted_out <= 1'b1;
			end else begin
				halt_cnt_q <= halt_cnt_q + 16'h0001;
			end
		end
	end

	// Interrupts are active low and ignored while halted
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			irq5_out <= 1'b0;
			irq6_out <= 1'b0;
		end else if (ce_in) begin
			irq5_out <= ~irq_level_five_n_in & ~halted_out;
			irq6_out <= ~irq_level_six_n_in & ~halted_out;
		end
	end

	// Spread rows over the period so a full sweep lands every 1.6 ms
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			ref_cnt_q <= 16'h0000;
			ref_due_q <= 1'b0;
		end else if (ce_in) begin
			if (ref_cnt_q >= REFRESH_CYCLES[15:0] / REFRESH_ROWS[15:0]
					- 16'h0001) begin
				ref_cnt_q <= 16'h0000;
				ref_due_q <= 1'b1;
			end else begin
				ref_cnt_q <= ref_cnt_q + 16'h0001;
				// Consumed as the idle sequencer launches the refresh read
				if (state_q == S_IDLE && quiet(sync_strobe_out, reply_strobe_in))
					ref_due_q <= 1'b0;
			end
		end
	end

	// Main bus sequencer
	always @(posedge clk_in) begin
		if (sys_rst_in) begin
			state_q <= S_IDLE;
			write_q <= 1'b0;
			refresh_cycle_q <= 1'b0;
			wdata_q <= {DATA_W{1'b0}};
			row_q <= 8'h00;
			req_ready_out <= 1'b0;
			rsp_valid_out <= 1'b0;
			rsp_rdata_out <= {DATA_W{1'b0}};
			rsp_err_out <= 1'b0;
			rsp_timeout_out <= 1'b0;
			dma_owner_out <= 1'b0;
			sync_strobe_out <= 1'b0;
			read_strobe_out <= 1'b0;
			write_strobe_out <= 1'b0;
			refresh_strobe_out <= 1'b0;
			dal_out <= {DATA_W{1'b0}};
			dal_oe_out <= 1'b0;
			ext_addr_bit_a_out <= 1'b0;
			ext_addr_bit_a_oe_out <= 1'b0;
			ext_addr_bit_b_out <= 1'b0;
			ext_addr_bit_b_oe_out <= 1'b0;
			dma_grant_out <= 1'b0;
		end else if (ce_in) begin
			rsp_valid_out <= 1'b0;
			case (state_q)
			S_IDLE: begin
				req_ready_out <= 1'b0;
				if (!quiet(sync_strobe_out, reply_strobe_in)) begin
					state_q <= S_IDLE;
				end else if (ref_due_q) begin
					// Refresh read: strobes refresh with sync and read
					refresh_cycle_q <= 1'b1;
					write_q <= 1'b0;
					row_q <= row_q + 8'h01;
					refresh_strobe_out <= 1'b1;
					dal_out <= {{(DATA_W-8){1'b0}}, row_q};
					dal_oe_out <= 1'b1;
					state_q <= S_ADDR;
				end else if (dma_request_line_in) begin
					dma_grant_out <= 1'b1;
					state_q <= S_GRANT;
				end else if (req_valid_in && !halted_out) begin
					req_ready_out <= 1'b1;
					refresh_cycle_q <= 1'b0;
					write_q <= req_write_in;
					wdata_q <= req_wdata_in;
					// Address phase drives low bits plus both extended bits
					dal_out <= req_addr_in[DATA_W-1:0];
					dal_oe_out <= 1'b1;
					ext_addr_bit_a_out <= req_addr_in[16];
					ext_addr_bit_a_oe_out <= 1'b1;
					ext_addr_bit_b_out <= req_addr_in[17];
					ext_addr_bit_b_oe_out <= 1'b1;
					state_q <= S_ADDR;
				end
			end
			S_ADDR: begin
				// Address set up one cycle before sync latches it
				req_ready_out <= 1'b0;
				sync_strobe_out <= 1'b1;
				state_q <= S_DATA;
			end
			S_DATA: begin
				// Data time: bit a turns input, bit b enables error logic
				ext_addr_bit_a_oe_out <= 1'b0;
				ext_addr_bit_b_out <= ~refresh_cycle_q;
				ext_addr_bit_b_oe_out <= 1'b1;
				if (write_q) begin
					dal_out <= wdata_q;
					write_strobe_out <= 1'b1;
				end else begin
					dal_oe_out <= 1'b0;
					read_strobe_out <= 1'b1;
				end
				if (reply_strobe_in && (write_q || read_strobe_out)) begin
					// Refresh reads leave the last user response standing
					if (!refresh_cycle_q) begin
						rsp_rdata_out <= dal_in;
						rsp_err_out <= ext_addr_bit_a_in & ~write_q;
						rsp_timeout_out <= 1'b0;
					end
					rsp_valid_out <= ~refresh_cycle_q;
					read_strobe_out <= 1'b0;
					write_strobe_out <= 1'b0;
					state_q <= S_TERM;
				end else if (tmo_done) begin
					// No slave decoded the address, so nobody replies
					if (!refresh_cycle_q) begin
						rsp_err_out <= 1'b0;
						rsp_timeout_out <= 1'b1;
					end
					rsp_valid_out <= ~refresh_cycle_q;
					read_strobe_out <= 1'b0;
					write_strobe_out <= 1'b0;
					state_q <= S_TERM;
				end
			end
			S_TERM: begin
				// Release sync only after reply drops
				if (!reply_strobe_in) begin
					sync_strobe_out <= 1'b0;
					refresh_strobe_out <= 1'b0;
					dal_oe_out <= 1'b0;
					ext_addr_bit_a_oe_out <= 1'b0;
					ext_addr_bit_b_oe_out <= 1'b0;
					state_q <= S_IDLE;
				end
			end
			S_GRANT: begin
				if (select_acknowledge_in && !dma_request_line_in) begin
					dma_grant_out <= 1'b0;
					dma_owner_out <= 1'b1;
					state_q <= S_DMA;
				end else if (!dma_request_line_in) begin
					dma_grant_out <= 1'b0;
					state_q <= S_IDLE;
				end
			end
			S_DMA: begin
				if (!select_acknowledge_in) begin
					dma_owner_out <= 1'b0;
					state_q <= S_IDLE;
				end
			end
			default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule // bus_master_ctrl
`default_nettype wire

/* File: tb/bus_master_ctrl_properties.sv */
// Port checks bound to the bus master controller
`default_nettype none
module bus_master_ctrl_properties #(parameter HALT_CYCLES = 250) (
	input wire logic clk_in, sys_rst_in, sync_strobe_out, read_strobe_out,
	input wire logic write_strobe_out, refresh_strobe_out, reply_strobe_in,
	input wire logic dma_grant_out, dma_owner_out, select_acknowledge_in,
	input wire logic dma_request_line_in, req_ready_out, halted_out,
	input wire logic halt_request_in, irq5_out, irq6_out,
	input wire logic ext_addr_bit_a_oe_out, ext_addr_bit_b_out,
	input wire logic ext_addr_bit_b_oe_out
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	int hc;
	// Run length of halt, cleared by reset so a new run starts fresh
	always @(posedge clk_in) hc <= halt_request_in && !sys_rst_in ? hc + 1 : 0;
	property p_grant; $rose(dma_grant_out) |-> !sync_strobe_out; endproperty
	a_grant: assert property (p_grant) else $error("grant in cycle");
	property p_take; dma_grant_out && select_acknowledge_in &&
		!dma_request_line_in |=> !dma_grant_out && dma_owner_out; endproperty
	a_take: assert property (p_take) else $error("no handover");
	property p_own; dma_owner_out |-> !req_ready_out; endproperty
	a_own: assert property (p_own) else $error("taken while dma");
	property p_start; $rose(sync_strobe_out) |-> $past(reply_strobe_in) == 0;
	endproperty
	a_start: assert property (p_start) else $error("sync over reply");
	property p_end; sync_strobe_out && reply_strobe_in |=>
		!read_strobe_out && !write_strobe_out; endproperty
	a_end: assert property (p_end) else $error("strobe after reply");
	property p_ext; (read_strobe_out || write_strobe_out) && !refresh_strobe_out
		|-> !ext_addr_bit_a_oe_out && ext_addr_bit_b_oe_out && ext_addr_bit_b_out;
	endproperty
	a_ext: assert property (p_ext) else $error("ext bits in data");
	property p_halt; ($rose(halted_out) |-> hc >= HALT_CYCLES - 1) and
		(hc > HALT_CYCLES + 1 |-> halted_out); endproperty
	a_halt: assert property (p_halt) else $error("halt timing");
	property p_mask; halted_out && $past(halted_out) |-> !irq5_out && !irq6_out;
	endproperty
	a_mask: assert property (p_mask) else $error("irq while halted");
endmodule // bus_master_ctrl_properties
bind bus_master_ctrl bus_master_ctrl_properties
	#(.HALT_CYCLES(HALT_CYCLES)) u_props (.clk_in(clk_in),
	.sys_rst_in(sys_rst_in), .sync_strobe_out(sync_strobe_out),
	.read_strobe_out(read_strobe_out), .write_strobe_out(write_strobe_out),
	.refresh_strobe_out(refresh_strobe_out),
	.reply_strobe_in(reply_strobe_in), .dma_grant_out(dma_grant_out),
	.dma_owner_out(dma_owner_out),
	.select_acknowledge_in(select_acknowledge_in),
	.dma_request_line_in(dma_request_line_in),
	.req_ready_out(req_ready_out), .halted_out(halted_out),
	.halt_request_in(halt_request_in), .irq5_out(irq5_out),
	.irq6_out(irq6_out), .ext_addr_bit_a_oe_out(ext_addr_bit_a_oe_out),
	.ext_addr_bit_b_out(ext_addr_bit_b_out),
	.ext_addr_bit_b_oe_out(ext_addr_bit_b_oe_out));
`default_nettype wire

/* File: tb/mem_slave_model.sv */
// Behavioural memory slave on the far side of the controller
`default_nettype none
module mem_slave_model #(parameter int TOP = 'h3FF) (
	input wire logic clk_in, sync_in, rd_in, wr_in, ref_in, err_en_in,
	input wire logic b_in, bit_a_in,
	input wire logic [15:0] dal_in,
	input wire logic [3:0] dly_in,
	output var logic rply_out = 0, err_out = 0,
	output var logic [15:0] dat_out = 0
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [17:0] a_q;
	logic [15:0] mem [int];
	int n;
	logic hit;
	// Latch address on first sync cycle; released lines flip every cycle
	always @(posedge clk_in) begin
		n = sync_in ? n + 1 : 0;
		if (n == 1) a_q = {b_in, bit_a_in, dal_in};
		hit = (rd_in || wr_in) && n > dly_in && (ref_in || a_q <= TOP);
		if (hit && wr_in) mem[a_q] = dal_in;
		rply_out <= hit;
		dat_out <= hit ? (mem.exists(a_q) ? mem[a_q] : 16'h0000) : ~dat_out;
		err_out <= hit ? rd_in && b_in && err_en_in : ~err_out;
	end
endmodule // mem_slave_model
`default_nettype wire

/* File: tb/tb_memory_slave_bus_control.sv */
// Self-checking bench for the controller against the memory model
`default_nettype none
module tb_memory_slave_bus_control;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_in = 0, sys_rst_in = 1, ce_in = 1, req_valid_in = 0;
	logic req_write_in = 0, dma_request_line_in = 0, select_acknowledge_in = 0;
	logic halt_request_in = 0, irq_level_five_n_in = 1, irq_level_six_n_in = 1;
	logic [21:0] req_addr_in = 0, ad;
	logic [15:0] req_wdata_in = 0, dal_out, sdat, rsp_rdata_out, wd;
	logic req_ready_out, rsp_valid_out, rsp_err_out, rsp_timeout_out;
	logic halted_out, irq5_out, irq6_out, dma_owner_out, sync_strobe_out;
	logic read_strobe_out, write_strobe_out, refresh_strobe_out, dal_oe_out;
	logic dma_grant_out, ext_addr_bit_a_out, ext_addr_bit_a_oe_out;
	logic ext_addr_bit_b_out, ext_addr_bit_b_oe_out, reply_strobe_in, serr;
	logic err_en = 0;
	logic [3:0] dly = 0;
	wire logic [15:0] dal_in = dal_oe_out ? dal_out : sdat;
	wire logic ext_addr_bit_a_in = ext_addr_bit_a_oe_out ? ext_addr_bit_a_out
		: serr;
	int error_cnt = 0, checks = 0, nref = 0, k, r;
	logic [15:0] ref_m [int];
	bus_master_ctrl #(.HALT_CYCLES(4), .REFRESH_CYCLES(256), .REFRESH_ROWS(4))
		i_bus_master_ctrl (.*);
	mem_slave_model i_mem_slave_model (.clk_in, .sync_in(sync_strobe_out),
		.rd_in(read_strobe_out), .wr_in(write_strobe_out),
		.ref_in(refresh_strobe_out), .err_en_in(err_en),
		.b_in(ext_addr_bit_b_oe_out & ext_addr_bit_b_out),
		.bit_a_in(ext_addr_bit_a_in), .dal_in, .dly_in(dly),
		.rply_out(reply_strobe_in), .err_out(serr), .dat_out(sdat));
	always #50 clk_in = ~clk_in;
	// Count refresh cycles to judge the refresh period
	always @(posedge refresh_strobe_out) nref++;
	// Watchdog of 30000 cycles, well past the thousand or so cycles the tests need
	initial begin
		#3000000;
		error_cnt++;
		conclude();
	end
	task automatic chk(input string nm, input logic [21:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("checks %0d error_cnt %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Wait a cycle past sync, hold the request through the ready edge
	task automatic xfer(input logic w, input logic [21:0] a, input logic [15:0] d);
		k = 0;
		while (sync_strobe_out !== 1'b0 && k++ < 50) tick(1);
		tick(1);
		{req_write_in, req_addr_in, req_wdata_in, req_valid_in} = {w, a, d, 1'b1};
		do tick(1); while (req_ready_out !== 1'b1 && ++k < 500);
		tick(1);
		req_valid_in = 0;
		while (rsp_valid_out !== 1'b1 && k++ < 700) tick(1);
		chk("rsp_valid", rsp_valid_out, 1);
	endtask
	task automatic rdchk(input logic [21:0] a);
		xfer(0, a, 0);
		chk("rdata", rsp_rdata_out, ref_m.exists(a) ? ref_m[a] : 0);
	endtask
	// Main sequence
	initial begin
		void'($urandom(51));
		tick(8);
		sys_rst_in = 0;
		for (int i = 0; i < 30; i++) begin
			dly = $urandom_range(6);
			ad = 22'h3F0 + $urandom_range(15);
			wd = $urandom;
			if ($urandom_range(1)) begin
				xfer(1, ad, wd);
				ref_m[ad] = wd;
			end else rdchk(ad);
		end
		err_en = 1;
		rdchk(22'h3F1);
		chk("err", rsp_err_out, 1);
		err_en = 0;
		xfer(0, 22'h000400, 0);
		chk("timeout", rsp_timeout_out, 1);
		rdchk(22'h3FF);
		chk("no_timeout", {rsp_timeout_out, rsp_err_out}, 0);
		r = nref;
		tick(260);
		chk("refresh", nref - r >= 4 && nref - r <= 5, 1);
		dma_request_line_in = 1;
		k = 0;
		while (dma_grant_out !== 1'b1 && k++ < 300) tick(1);
		chk("grant_sync", {dma_grant_out, sync_strobe_out}, 2);
		{dma_request_line_in, select_acknowledge_in} = 2'b01;
		tick(4);
		chk("owner", {dma_owner_out, dma_grant_out}, 2);
		select_acknowledge_in = 0;
		tick(3);
		chk("owner_off", dma_owner_out, 0);
		rdchk(22'h3F2);
		halt_request_in = 1;
		tick(3);
		halt_request_in = 0;
		irq_level_five_n_in = 0;
		tick(3);
		chk("short_halt", {halted_out, irq5_out}, 1);
		{halt_request_in, irq_level_six_n_in} = 2'b10;
		tick(8);
		chk("halted", {halted_out, irq5_out, irq6_out}, 4);
		halt_request_in = 0;
		tick(4);
		chk("irq_back", {halted_out, irq5_out, irq6_out}, 3);
		// Enable low freezes every register, the irq levels included
		{ce_in, irq_level_five_n_in} = 2'b01;
		tick(3);
		chk("ce_hold", irq5_out, 1);
		ce_in = 1;
		tick(2);
		chk("ce_run", irq5_out, 0);
		conclude();
	end
endmodule // tb_memory_slave_bus_control
`default_nettype wire
